// [hw/lai_top.sv]
// Interrupt enable, status and output logic for the link authentication engine.
// Assumes event inputs synchronous to sys_clk and an AHB-Lite master with single word transfers.
//
// Overview of operation
// - With enable bit 5 set, a downstream receiver interrupt raises the interrupt.
// - With enable bit 4 set, the key list becoming ready raises the interrupt.
// - With enable bit 3 set, the receiver key becoming ready raises the interrupt.
// - With enable bit 2 set, both a failed and a lost authentication raise the interrupt.
// - With enable bit 1 set, a successful authentication raises the interrupt.
// - Control bit 0 is a global gate without which no event reaches the interrupt line.
// - Status bit 7 reports a finished indirect register access.
// - Status bit 6 reports a found receiver, held back until lock when the lock-wait select is one.
// - Status bit 5 reports an interrupt forwarded by the downstream receiver.
// - Status bit 4 reports that the key selection vector list is ready to read.
// - Status bit 3 reports that the receiver key selection vector is ready to read.
// - Status bit 2 reports failed or lost authentication.
// - Status bit 1 reports successful authentication.
// - Status bit 0 is set while any event that is individually enabled and set in the event mask is indicated.
// - With enable bit 7 set, a finished indirect access raises the interrupt.
// - With enable bit 6 set, a found receiver raises the interrupt under the same lock-wait option.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module lai_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event sources
  input wire lai_pkg::lai_events_t events,
  // Interrupt to the controller
  output logic irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] interrupt_control_reg;
  logic [7:0] event_status_reg;
  logic [7:0] event_status_next;
  logic [7:0] event_mask_reg;
  logic [7:0] config_reg;
  logic found_cond;
  logic found_cond_reg;
  logic downstream_reg;
  logic [7:0] event_set;
  logic [7:0] interrupt_status;
  logic combined_flag;
  lai_pkg::lai_req_t req_reg;
  logic addr_phase;
  logic [7:0] read_byte;

  // ==========================================================================
  // Event detection
  // ==========================================================================
  assign found_cond = config_reg[lai_pkg::BIT_DETECT_WAITS_LOCK] ?
    (events.receiver_detect & events.receiver_lock) : events.receiver_detect;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      found_cond_reg <= 1'b0;
      downstream_reg <= 1'b0;
    end else begin
      found_cond_reg <= found_cond;
      downstream_reg <= events.downstream_irq;
    end
  end

  always_comb begin
    event_set = 8'h00;
    event_set[lai_pkg::BIT_INDIRECT_DONE] = events.indirect_done;
    event_set[lai_pkg::BIT_RECEIVER_FOUND] = found_cond & ~found_cond_reg;
    event_set[lai_pkg::BIT_DOWNSTREAM_IRQ] = events.downstream_irq & ~downstream_reg;
    event_set[lai_pkg::BIT_KEY_LIST_READY] = events.key_list_ready;
    event_set[lai_pkg::BIT_RECEIVER_KEY_READY] = events.receiver_key_ready;
    event_set[lai_pkg::BIT_AUTH_FAIL] = events.auth_fail;
    event_set[lai_pkg::BIT_AUTH_PASS] = events.auth_pass;
  end

  // ==========================================================================
  // Bus address phase
  // ==========================================================================
  assign addr_phase = hsel & hready & (htrans == lai_pkg::HTRANS_NONSEQ) & (hsize == lai_pkg::HSIZE_WORD);
  assign hreadyout = 1'b1;
  assign hresp = lai_pkg::HRESP_OKAY;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_reg <= '0;
    end else if (hready) begin
      req_reg.sel <= addr_phase;
      req_reg.write <= hwrite;
      req_reg.addr <= haddr[lai_pkg::ADDR_W-1:0];
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interrupt_control_reg <= lai_pkg::RST_INTERRUPT_CONTROL;
      event_mask_reg <= lai_pkg::RST_EVENT_MASK;
      config_reg <= lai_pkg::RST_CONFIG;
    end else if (req_reg.sel && req_reg.write) begin
      if (req_reg.addr == lai_pkg::ADDR_INTERRUPT_CONTROL) begin
        interrupt_control_reg <= hwdata[7:0];
      end else if (req_reg.addr == lai_pkg::ADDR_EVENT_MASK) begin
        event_mask_reg <= hwdata[7:0] & lai_pkg::EVENT_BITS;
      end else if (req_reg.addr == lai_pkg::ADDR_CONFIG) begin
        config_reg <= {7'h00, hwdata[lai_pkg::BIT_DETECT_WAITS_LOCK]};
      end
    end
  end

  // Sticky flags: a set arriving with a write-one clear wins.
  always_comb begin
    event_status_next = event_status_reg;
    if (req_reg.sel && req_reg.write && (req_reg.addr == lai_pkg::ADDR_EVENT_STATUS)) begin
      event_status_next = event_status_reg & ~hwdata[7:0];
    end
    event_status_next = (event_status_next | event_set) & lai_pkg::EVENT_BITS;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      event_status_reg <= lai_pkg::RST_EVENT_STATUS;
    end else begin
      event_status_reg <= event_status_next;
    end
  end

  // ==========================================================================
  // Combined flag and interrupt output
  // ==========================================================================
  // Enable bits 7..1 select events; the mask narrows them further.
  assign combined_flag = |(event_status_reg & interrupt_control_reg & event_mask_reg
    & lai_pkg::EVENT_BITS);
  assign interrupt_status = {event_status_reg[7:1], combined_flag};
  assign irq = interrupt_control_reg[lai_pkg::BIT_GLOBAL] & combined_flag;

  // ==========================================================================
  // Read data
  // ==========================================================================
  always_comb begin
    read_byte = 8'h00;
    if (haddr[lai_pkg::ADDR_W-1:0] == lai_pkg::ADDR_INTERRUPT_CONTROL) begin
      read_byte = interrupt_control_reg;
    end else if (haddr[lai_pkg::ADDR_W-1:0] == lai_pkg::ADDR_INTERRUPT_STATUS) begin
      read_byte = interrupt_status;
    end else if (haddr[lai_pkg::ADDR_W-1:0] == lai_pkg::ADDR_EVENT_STATUS) begin
      read_byte = event_status_reg;
    end else if (haddr[lai_pkg::ADDR_W-1:0] == lai_pkg::ADDR_EVENT_MASK) begin
      read_byte = event_mask_reg;
    end else if (haddr[lai_pkg::ADDR_W-1:0] == lai_pkg::ADDR_CONFIG) begin
      read_byte = config_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h000000, read_byte};
    end
  end

endmodule

// [hw/lai_pkg.sv]
// Constants, field layouts and carrier types of the link authentication interrupt logic.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package lai_pkg;

  // ==========================================================================
  // Register indexes and byte addresses
  // ==========================================================================
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h0c6;
  localparam logic [9:0] IDX_INTERRUPT_STATUS = 10'h0c7;
  localparam logic [11:0] ADDR_INTERRUPT_CONTROL = {IDX_INTERRUPT_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_INTERRUPT_STATUS = {IDX_INTERRUPT_STATUS, 2'h0};
  localparam logic [11:0] ADDR_EVENT_STATUS = 12'h000;
  localparam logic [11:0] ADDR_EVENT_MASK = 12'h004;
  localparam logic [11:0] ADDR_CONFIG = 12'h008;
  localparam int ADDR_W = 12;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int BIT_INDIRECT_DONE = 7;
  localparam int BIT_RECEIVER_FOUND = 6;
  localparam int BIT_DOWNSTREAM_IRQ = 5;
  localparam int BIT_KEY_LIST_READY = 4;
  localparam int BIT_RECEIVER_KEY_READY = 3;
  localparam int BIT_AUTH_FAIL = 2;
  localparam int BIT_AUTH_PASS = 1;
  localparam int BIT_GLOBAL = 0;
  localparam int BIT_DETECT_WAITS_LOCK = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'hfe;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] EVENT_BITS = 8'hfe;

  // ==========================================================================
  // AHB-Lite encodings
  // ==========================================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic indirect_done;
    logic receiver_detect;
    logic receiver_lock;
    logic downstream_irq;
    logic key_list_ready;
    logic receiver_key_ready;
    logic auth_fail;
    logic auth_pass;
  } lai_events_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [ADDR_W-1:0] addr;
  } lai_req_t;

endpackage

// [testbench/lai_monitor.sv]
// Port checker of the link authentication interrupt logic.
// Assumes it is bound into lai_top.
`timescale 1ns/100ps
module lai_monitor (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Events and interrupt
  input wire lai_pkg::lai_events_t events,
  input wire logic irq
);
  // ==========
  // Shadow of the control register and the checks.
  logic wr_ph;
  logic [11:0] wa;
  logic [7:0] ctl;
  logic [7:0] msk;
  logic cfg;
  logic found;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ph <= 1'h0;
      wa <= 12'h000;
      ctl <= 8'h00;
      msk <= lai_pkg::RST_EVENT_MASK;
      cfg <= 1'h0;
    end else begin
      if (wr_ph && wa == lai_pkg::ADDR_INTERRUPT_CONTROL) begin
        ctl <= hwdata[7:0];
      end else if (wr_ph && wa == lai_pkg::ADDR_EVENT_MASK) begin
        msk <= hwdata[7:0] & lai_pkg::EVENT_BITS;
      end else if (wr_ph && wa == lai_pkg::ADDR_CONFIG) begin
        cfg <= hwdata[0];
      end
      wr_ph <= hsel && hready && htrans == lai_pkg::HTRANS_NONSEQ && hwrite && hsize == lai_pkg::HSIZE_WORD;
      wa <= haddr[11:0];
    end
  end
  // Found condition, held back until lock when the lock-wait select is one.
  assign found = cfg ? (events.receiver_detect && events.receiver_lock) : events.receiver_detect;
  sequence s_ev(en, ev);
    ctl[0] && en && ev;
  endsequence
  property p_irq(en, ev);
    s_ev(en, ev) |=> irq;
  endproperty
  a_bus_okay: assert property (hreadyout && hresp == lai_pkg::HRESP_OKAY) else $error("bus not ready");
  a_gate_off: assert property (!ctl[0] |-> !irq) else $error("irq without gate");
  a_down_irq: assert property (p_irq(ctl[5] && msk[5], $rose(events.downstream_irq))) else $error("no irq");
  a_list_irq: assert property (p_irq(ctl[4] && msk[4], events.key_list_ready)) else $error("no irq");
  a_key_irq: assert property (p_irq(ctl[3] && msk[3], events.receiver_key_ready)) else $error("no irq");
  a_fail_irq: assert property (p_irq(ctl[2] && msk[2], events.auth_fail)) else $error("no irq");
  a_pass_irq: assert property (p_irq(ctl[1] && msk[1], events.auth_pass)) else $error("no irq");
  a_done_irq: assert property (p_irq(ctl[7] && msk[7], events.indirect_done)) else $error("no irq");
  a_found_irq: assert property (p_irq(ctl[6] && msk[6], $rose(found))) else $error("no irq");
endmodule
bind lai_top lai_monitor mon_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .events(events), .irq(irq));

// [testbench/lai_host.sv]
// Host controller model: AHB-Lite master of single word transfers.
// Assumes hready comes from the one slave.
`timescale 1ns/100ps
module lai_host (
  // Clock
  input wire logic sys_clk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // ==========
  // One transfer; read data is handed on through the event.
  logic [31:0] rdat;
  event got;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'h1;
    htrans <= lai_pkg::HTRANS_NONSEQ;
    haddr <= {20'h00000, a};
    hwrite <= w;
    hsize <= lai_pkg::HSIZE_WORD;
    @(posedge sys_clk);
    while (hready !== 1'h1) @(posedge sys_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'h1) @(posedge sys_clk);
    rdat = hrdata;
    if (!w) -> got;
  endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench of the link authentication interrupt logic.
// Assumes lai_top, lai_host and lai_monitor are compiled first.
`timescale 1ns/100ps
module tb;
  // ==========
  // Stimulus, expectations and verdict.
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  lai_pkg::lai_events_t ev = '0;
  logic hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] q[$];
  logic [11:0] ra[6] = '{12'h318, 12'h31c, 12'h000, 12'h004, 12'h008, 12'h100};
  logic [31:0] re[6] = '{32'h0, 32'h0, 32'h0, 32'hfe, 32'h0, 32'h0};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 sys_clk = ~sys_clk;
  lai_host host_u (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  lai_top dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .events(ev), .irq(irq));
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    host_u.xfer(1'h0, a, 32'h0);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    host_u.xfer(1'h1, a, {24'h0, d});
  endtask
  task pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'h1;
    @(posedge sys_clk);
    ev[i] <= 1'h0;
  endtask
  task irq_is(input logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task results;
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(host_u.got) chk("hrdata", q.pop_front(), host_u.rdat);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    void'($urandom(29152));
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) rd(ra[i], re[i]);
    r = $urandom();
    wr(12'h318, r[7:0]);
    rd(12'h318, {24'h0, r[7:0]});
    wr(12'h318, 8'hff);
    for (int b = 1; b < 8; b++) begin
      pulse(b > 5 ? b : b - 1);
      irq_is(1'h1);
      rd(12'h31c, 32'h1 | (32'h1 << b));
      wr(12'h000, 8'h01 << b);
      irq_is(1'h0);
    end
    wr(12'h318, 8'hfe);
    pulse(0);
    irq_is(1'h0);
    rd(12'h31c, 32'h3);
    wr(12'h318, 8'hff);
    irq_is(1'h1);
    wr(12'h004, 8'h00);
    irq_is(1'h0);
    wr(12'h004, 8'hfe);
    wr(12'h318, 8'h01);
    rd(12'h31c, 32'h2);
    wr(12'h000, 8'h02);
    wr(12'h008, 8'h01);
    ev.receiver_detect <= 1'h1;
    rd(12'h31c, 32'h0);
    ev.receiver_lock <= 1'h1;
    rd(12'h31c, 32'h40);
    wr(12'h318, 8'h41);
    irq_is(1'h1);
    results();
  end
endmodule
